// ==== core/receive_input_pkg.sv ====
package receive_input_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_FMT     = 4'h4;
  localparam logic [3:0]  ADDR_DELAY   = 4'h8;
  localparam logic [3:0]  ADDR_STATUS  = 4'hc;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int          CTRL_BYPASS  = 0;
  localparam int          CTRL_RATE    = 1;
  localparam int          CTRL_FSYNC   = 3;
  localparam int          CTRL_DSYNC   = 6;
  localparam int          CTRL_PAIR_AB = 9;
  localparam int          CTRL_PAIR_CD = 10;
  localparam int          CTRL_TESTBUS = 11;
  localparam int          CTRL_LFSR    = 12;
  localparam int          CTRL_NOISE   = 13;
  localparam int          CTRL_MAP     = 14;
  localparam logic [31:0] CTRL_RST     = 32'h0039_0000;

  // ****************************************
  // Format and delay fields
  // ****************************************
  localparam int          FMT_OFFSET   = 0;
  localparam int          FMT_MSB      = 4;
  localparam int          FMT_MSB_W    = 3;
  localparam logic [31:0] FMT_RST      = 32'h0000_0000;
  localparam int          DLY_STEP     = 8;
  localparam logic [31:0] DLY_RST      = 32'h0000_0000;

  // ****************************************
  // FIFO, generator and noise constants
  // ****************************************
  localparam logic [2:0]  FIFO_LEAD    = 3'h4;
  localparam logic [2:0]  FIFO_RD_RST  = 3'h0;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;
  localparam logic [15:0] LFSR_TAPS    = 16'hb400;
  localparam int          NOISE_SHIFT  = 4;

endpackage

// ==== core/receive_input_interface.sv ====
// What this block does
// - Four 16-bit sample ports are accepted and forwarded to the channels.
// - Per-port format bit: set means offset binary, clear two's complement.
// - Per-port 3-bit field puts the converter MSB at input bit 15 down to 8.
// - Complex mode pairs I and Q ports; port-to-output mapping is programmable.
// - Each port has an 8-stage FIFO, source-clock write, receive-clock read.
// - Selected sync sets write pointer four samples ahead of read pointer.
// - Every source clock rising edge stores a sample and advances write pointer; paired ports b and d follow the a and c edges instead.
// - FIFO reads on receive clock divided by 1, 2, 4 or 8 per rate field.
// - Bypass skips FIFOs and latches input on the receive clock directly.
// - A 3-bit field selects the sync source that initialises FIFO pointers.
// - Pairing bits keep pointers of ports a/b and c/d in step.
// - A 3-bit field selects the sync source for channel input and mixer.
// - Integrated-converter ports decimate by 32 onto the test-bus outputs.
// - With test bus enabled, ports c and d are driven as outputs.
// - Each of the four streams passes a 1 to 64 sample delay line.
// - LFSR test sequence generator and optional noise added to streams.
// - All four streams are carried to each of the 8 channel blocks.
// - Ports a and b take 14-bit two's complement converter samples.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module receive_input_interface #(
  parameter int W       = 16,
  parameter int DEPTH   = 8,
  parameter int DLY_LEN = 64,
  parameter int DEC     = 32,
  parameter int N_DDC   = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // Sample ports a and b (integrated converters)
  input  wire logic [W-1:0]         rxin_a,
  input  wire logic                 adc_clk_a,
  input  wire logic [W-1:0]         rxin_b,
  input  wire logic                 adc_clk_b,
  // Sample ports c and d (two-way)
  input  wire logic [W-1:0]         rxin_c_in,
  output logic      [W-1:0]         rxin_c_out,
  output logic                      rxin_c_oe_b,
  input  wire logic                 adc_clk_c,
  input  wire logic [W-1:0]         rxin_d_in,
  output logic      [W-1:0]         rxin_d_out,
  output logic                      rxin_d_oe_b,
  input  wire logic                 adc_clk_d,
  // Sync sources
  input  wire logic [7:0]           sync_src,
  // Distribution bus
  output logic      [N_DDC*4*W-1:0] ddc_bus,
  output logic                      ddc_valid,
  output logic                      ddc_sync,
  output logic                      test_bus_valid
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [W-1:0] align(input logic [W-1:0] raw,
                                         input logic [2:0]   pos,
                                         input logic         ob);
    logic [W-1:0] s;
    s = raw << pos;
    s[W-1] = s[W-1] ^ ob;
    return s;
  endfunction

  function automatic logic [2:0] rate_mask(input logic [1:0] r);
    logic [2:0] m;
    case (r)
      2'h0:    m = 3'h0;
      2'h1:    m = 3'h1;
      2'h2:    m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0]    ctrl_reg;
  logic [31:0]    fmt_reg;
  logic [31:0]    dly_reg;
  logic [31:0]    rdata_next;
  logic [15:0]    lfsr_reg;
  logic [2:0]     wp [4];
  logic [2:0]     rp [4];
  logic [11:0]    fill;

  logic           bypass;
  logic [1:0]     rate;
  logic [2:0]     fsel;
  logic [2:0]     dsel;
  logic [1:0]     pair;
  logic           tb_en;

  assign bypass = ctrl_reg[receive_input_pkg::CTRL_BYPASS];
  assign rate   = ctrl_reg[receive_input_pkg::CTRL_RATE +: 2];
  assign fsel   = ctrl_reg[receive_input_pkg::CTRL_FSYNC +: 3];
  assign dsel   = ctrl_reg[receive_input_pkg::CTRL_DSYNC +: 3];
  assign pair   = {ctrl_reg[receive_input_pkg::CTRL_PAIR_CD],
                   ctrl_reg[receive_input_pkg::CTRL_PAIR_AB]};
  assign tb_en  = ctrl_reg[receive_input_pkg::CTRL_TESTBUS];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= receive_input_pkg::CTRL_RST;
      fmt_reg  <= receive_input_pkg::FMT_RST;
      dly_reg  <= receive_input_pkg::DLY_RST;
    end else if (reg_wr) begin
      if (reg_addr == receive_input_pkg::ADDR_CTRL) begin
        ctrl_reg <= {10'h0, reg_wdata[21:0]};
      end
      if (reg_addr == receive_input_pkg::ADDR_FMT) begin
        fmt_reg <= {16'h0, reg_wdata[15:0]};
      end
      if (reg_addr == receive_input_pkg::ADDR_DELAY) begin
        dly_reg <= reg_wdata & 32'h3f3f_3f3f;
      end
    end
  end

  assign fill = {3'(wp[3] - rp[3]), 3'(wp[2] - rp[2]),
                 3'(wp[1] - rp[1]), 3'(wp[0] - rp[0])};

  always_comb begin
    case (reg_addr)
      receive_input_pkg::ADDR_CTRL:   rdata_next = ctrl_reg;
      receive_input_pkg::ADDR_FMT:    rdata_next = fmt_reg;
      receive_input_pkg::ADDR_DELAY:  rdata_next = dly_reg;
      receive_input_pkg::ADDR_STATUS: rdata_next = {lfsr_reg, 4'h0, fill};
      default:                        rdata_next = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0;
    end
  end

  // ****************************************
  // Sync selection
  // ****************************************
  logic [7:0] sync_s1;
  logic [7:0] sync_s2;
  logic [7:0] sync_s3;
  logic       fsync_ev;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_s1 <= 8'h0;
      sync_s2 <= 8'h0;
      sync_s3 <= 8'h0;
      ddc_sync <= 1'b0;
    end else begin
      sync_s1 <= sync_src;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      ddc_sync <= sync_s2[dsel] & ~sync_s3[dsel];
    end
  end

  assign fsync_ev = sync_s2[fsel] & ~sync_s3[fsel];

  // ****************************************
  // Read rate divider
  // ****************************************
  logic [2:0] div_reg;
  logic       rd_tick;
  logic       adv;

  always_ff @(posedge clk) begin
    if (!rst_b || fsync_ev) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  assign rd_tick = (div_reg & rate_mask(rate)) == 3'h0;
  assign adv     = bypass | rd_tick;
  assign ddc_valid = adv;

  // ****************************************
  // Test sequence and noise
  // ****************************************
  logic [W-1:0] noise;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lfsr_reg <= receive_input_pkg::LFSR_SEED;
    end else if (adv) begin
      lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ receive_input_pkg::LFSR_TAPS)
                              : (lfsr_reg >> 1);
    end
  end

  // Small noise keeps desensitisation from swamping the signal
  assign noise = W'($signed(lfsr_reg) >>> receive_input_pkg::NOISE_SHIFT);

  // ****************************************
  // Per-port capture and FIFO
  // ****************************************
  logic [W-1:0] pin_d [4];
  logic [3:0]   pin_c;
  logic [3:0]   wr_edge;
  logic [3:0]   wen;
  logic [W-1:0] conv [4];
  logic [W-1:0] strm [4];

  assign pin_d[0] = rxin_a;
  assign pin_d[1] = rxin_b;
  assign pin_d[2] = rxin_c_in;
  assign pin_d[3] = rxin_d_in;
  assign pin_c    = {adc_clk_d, adc_clk_c, adc_clk_b, adc_clk_a};

  for (genvar i = 0; i < 4; i++) begin : g_port
    logic [W-1:0] d_s1;
    logic [W-1:0] d_s2;
    logic [2:0]   c_sh;
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] samp_reg;

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        d_s1 <= '0;
        d_s2 <= '0;
        c_sh <= 3'h0;
      end else begin
        d_s1 <= pin_d[i];
        d_s2 <= d_s1;
        c_sh <= {c_sh[1:0], pin_c[i]};
      end
    end

    assign wr_edge[i] = c_sh[1] & ~c_sh[2];

    if (i % 2 == 1) begin : g_pair
      assign wen[i] = pair[i/2] ? wr_edge[i-1] : wr_edge[i];
    end else begin : g_solo
      assign wen[i] = wr_edge[i];
    end

    always_ff @(posedge clk) begin
      if (!rst_b || fsync_ev) begin
        wp[i] <= receive_input_pkg::FIFO_LEAD;
        rp[i] <= receive_input_pkg::FIFO_RD_RST;
      end else begin
        if (wen[i]) begin
          wp[i] <= wp[i] + 3'h1;
        end
        if (rd_tick && !bypass) begin
          rp[i] <= rp[i] + 3'h1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (wen[i]) begin
        mem[wp[i]] <= d_s2;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        samp_reg <= '0;
      end else if (bypass) begin
        samp_reg <= d_s2;
      end else if (rd_tick) begin
        samp_reg <= mem[rp[i]];
      end
    end

    assign conv[i] = align(samp_reg,
      fmt_reg[receive_input_pkg::FMT_MSB + i*receive_input_pkg::FMT_MSB_W
              +: receive_input_pkg::FMT_MSB_W],
      fmt_reg[receive_input_pkg::FMT_OFFSET + i]);

    assign strm[i] = ctrl_reg[receive_input_pkg::CTRL_LFSR] ? lfsr_reg :
      conv[i] + (ctrl_reg[receive_input_pkg::CTRL_NOISE] ? noise : '0);
  end

  // ****************************************
  // Output mapping and delay lines
  // ****************************************
  logic [W-1:0] dl_out [4];

  for (genvar j = 0; j < 4; j++) begin : g_out
    logic [W-1:0] dmem [DLY_LEN];
    logic [5:0]   wi_reg;
    logic [1:0]   src;
    logic [5:0]   dly;
    logic [W-1:0] q_reg;

    assign src = ctrl_reg[receive_input_pkg::CTRL_MAP + 2*j +: 2];
    assign dly = dly_reg[j*receive_input_pkg::DLY_STEP +: 6];

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        wi_reg <= 6'h0;
        q_reg  <= '0;
      end else if (adv) begin
        wi_reg <= wi_reg + 6'h1;
        q_reg  <= dmem[6'(wi_reg - dly - 6'h1)];
      end
    end

    // Written after the read so a 64-sample delay sees the oldest word
    always_ff @(posedge clk) begin
      if (adv) begin
        dmem[wi_reg] <= strm[src];
      end
    end

    assign dl_out[j] = q_reg;
  end

  for (genvar k = 0; k < N_DDC; k++) begin : g_ddc
    assign ddc_bus[k*4*W +: 4*W] =
      {dl_out[3], dl_out[2], dl_out[1], dl_out[0]};
  end

  // ****************************************
  // Test bus decimator
  // ****************************************
  logic [4:0] dec_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dec_reg        <= 5'h0;
      rxin_c_out     <= '0;
      rxin_d_out     <= '0;
      test_bus_valid <= 1'b0;
    end else begin
      test_bus_valid <= 1'b0;
      // Skip the edge on which software turns the test bus off, so the
      // pins are never updated or flagged while being released
      if (tb_en && adv && !(reg_wr && reg_addr == receive_input_pkg::ADDR_CTRL
          && !reg_wdata[receive_input_pkg::CTRL_TESTBUS])) begin
        dec_reg <= dec_reg + 5'h1;
        if (dec_reg == 5'(DEC - 1)) begin
          rxin_c_out     <= conv[0];
          rxin_d_out     <= conv[1];
          test_bus_valid <= 1'b1;
        end
      end
    end
  end

  // Drive low enable means the pin is driven
  assign rxin_c_oe_b = ~tb_en;
  assign rxin_d_oe_b = ~tb_en;

endmodule

`default_nettype wire

// ==== testbench/receive_input_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module receive_input_chk #(
  parameter int W     = 16,
  parameter int N_DDC = 8
) (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic [W-1:0]         rxin_c_out,
  input wire logic                 rxin_c_oe_b,
  input wire logic                 rxin_d_oe_b,
  input wire logic [7:0]           sync_src,
  input wire logic [N_DDC*4*W-1:0] ddc_bus,
  input wire logic                 ddc_valid,
  input wire logic                 ddc_sync,
  input wire logic                 test_bus_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_oe_pair;
    rxin_c_oe_b == rxin_d_oe_b;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("oe split");
  property p_tbv_oe;
    test_bus_valid |-> !rxin_c_oe_b && !rxin_d_oe_b;
  endproperty
  a_tbv_oe: assert property (p_tbv_oe) else $error("pins not driven");
  property p_tbv_gap;
    test_bus_valid |=> !test_bus_valid [*8];
  endproperty
  a_tbv_gap: assert property (p_tbv_gap) else $error("test gap");
  property p_tb_out;
    !$stable(rxin_c_out) |-> test_bus_valid;
  endproperty
  a_tb_out: assert property (p_tb_out) else $error("stray update");
  property p_dsync_src;
    ddc_sync |-> $past(sync_src, 2) != 8'h00;
  endproperty
  a_dsync_src: assert property (p_dsync_src) else $error("no source");
  property p_dsync_pulse;
    ddc_sync |=> !ddc_sync;
  endproperty
  a_dsync_pulse: assert property (p_dsync_pulse) else $error("sync long");
  property p_bus_hold;
    !$past(ddc_valid) |-> $stable(ddc_bus);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus moved");
  property p_bcast;
    ddc_bus == {N_DDC{ddc_bus[4*W-1:0]}};
  endproperty
  a_bcast: assert property (p_bcast) else $error("slices differ");
endmodule
bind receive_input_interface receive_input_chk #(.W(W), .N_DDC(N_DDC)) u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .rxin_c_out(rxin_c_out),
  .rxin_c_oe_b(rxin_c_oe_b),
  .rxin_d_oe_b(rxin_d_oe_b),
  .sync_src(sync_src),
  .ddc_bus(ddc_bus),
  .ddc_valid(ddc_valid),
  .ddc_sync(ddc_sync),
  .test_bus_valid(test_bus_valid)
);
`default_nettype wire

// ==== testbench/conv_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Converter model
// ****
module conv_source (
  // Control
  input wire logic [3:0]  run,
  input wire logic [63:0] samples,
  // Pins
  output logic     [15:0] rxin_a,
  output logic     [15:0] rxin_b,
  output logic     [15:0] rxin_c,
  output logic     [15:0] rxin_d,
  output logic     [3:0]  adc_clk
);
  // Integrated converters give 14-bit words, sign-extended
  assign rxin_a = {{2{samples[13]}}, samples[13:0]};
  assign rxin_b = {{2{samples[29]}}, samples[29:16]};
  assign rxin_c = samples[47:32];
  assign rxin_d = samples[63:48];
  // Clock stands low while idle; 80 ns keeps it within the sample rate
  for (genvar i = 0; i < 4; i++) begin : g_clk
    logic ck = 1'b0;
    assign adc_clk[i] = ck;
    always begin
      wait (run[i]);
      #40 ck = 1'b1;
      #40 ck = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/receive_input_interface_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
// ****
// Bench
// ****
module receive_input_interface_bench;
  typedef struct packed {
    logic [3:0]  a;
    logic [31:0] v;
    logic [31:0] e;
  } row_t;
  row_t rows [6] = '{'{4'h0, 32'hffff_ffff, 32'h003f_ffff},
    '{4'h8, 32'hffff_ffff, 32'h3f3f_3f3f}, '{4'h2, 32'hffff_ffff, 32'h0},
    '{4'h8, 32'h0, 32'h0}, '{4'h4, 32'h0000_2003, 32'h0000_2003},
    '{4'h0, 32'h0039_0001, 32'h0039_0001}};
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [3:0]   reg_addr = 4'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic [7:0]   sync_src = 8'h0;
  logic [3:0]   run = 4'h0;
  logic [63:0]  smp = 64'h5a5a_0abc_300d_1234;
  logic [31:0]  reg_rdata, d;
  logic [15:0]  ra, rb, pc, pd, c_out, d_out, c_in, d_in, l;
  logic [3:0]   ac;
  logic         c_oe_b, d_oe_b, ddc_valid, ddc_sync, tbv;
  logic [511:0] ddc_bus;
  int           err_count = 0;
  int           comparisons = 0;
  int           n;
  int           k;
  always #5 clk = ~clk;
  // Pin level: the model drives unless the block has taken the pin
  assign c_in = c_oe_b ? pc : c_out;
  assign d_in = d_oe_b ? pd : d_out;
  conv_source u_conv_source (.run(run), .samples(smp), .rxin_a(ra),
    .rxin_b(rb), .rxin_c(pc), .rxin_d(pd), .adc_clk(ac));
  receive_input_interface u_receive_input_interface (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rxin_a(ra), .adc_clk_a(ac[0]), .rxin_b(rb), .adc_clk_b(ac[1]),
    .rxin_c_in(c_in), .rxin_c_out(c_out), .rxin_c_oe_b(c_oe_b),
    .adc_clk_c(ac[2]), .rxin_d_in(d_in), .rxin_d_out(d_out),
    .rxin_d_oe_b(d_oe_b), .adc_clk_d(ac[3]), .sync_src(sync_src),
    .ddc_bus(ddc_bus), .ddc_valid(ddc_valid), .ddc_sync(ddc_sync),
    .test_bus_valid(tbv));
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic cnt(input int cyc, input int w);
    n = 0;
    repeat (cyc) begin
      @(negedge clk);
      n += (w == 0) ? ddc_valid : (w == 1) ? tbv : ddc_sync;
    end
  endtask
  task automatic sy(input int b);
    @(posedge clk);
    sync_src[b] <= 1'b1;
    repeat (6) @(posedge clk);
    sync_src[b] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Three source edges; stop off the clock edge to avoid a fourth
  task automatic edges(input logic [3:0] m);
    @(posedge clk);
    run <= m;
    #235 run = 4'h0;
    repeat (10) @(posedge clk);
  endtask
  // Cycles from a change on port a until output 0 shows it
  task automatic lat(input logic [7:0] dl, output int c);
    wr(4'h8, {24'h0, dl});
    repeat (70) @(posedge clk);
    d = ddc_bus[31:0];
    smp <= smp ^ 64'h0100;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (ddc_bus[31:0] === d && c < 100);
  endtask
  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("oe", 2'b11, {c_oe_b, d_oe_b})
    // Software sets offset binary on a and b, msb of d at bit 14
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].v);
      rd(rows[i].a);
      `CHK("reg", rows[i].e, d)
    end
    repeat (10) @(posedge clk);
    `CHK("bus", 64'hb4b4_0abc_700d_9234, ddc_bus[63:0])
    wr(4'h0, 32'h0006_c001);
    repeat (10) @(posedge clk);
    `CHK("map", 64'h9234_700d_0abc_b4b4, ddc_bus[511:448])
    wr(4'h0, 32'h0039_0801);
    cnt(320, 1);
    `CHK("tbn", 10, n)
    `CHK("oe", 2'b00, {c_oe_b, d_oe_b})
    `CHK("tbo", 32'h9234_700d, {c_out, d_out})
    // Rate field kept equal to the channel divider
    for (int r = 0; r < 4; r++) begin
      wr(4'h0, 32'h0039_0000 | (r << 1));
      cnt(64, 0);
      `CHK("rate", 64 >> r, n)
    end
    wr(4'h0, 32'h0039_0029);
    sy(5);
    rd(4'hc);
    `CHK("fill", 12'h924, d[11:0])
    edges(4'h1);
    rd(4'hc);
    `CHK("fill", 12'h927, d[11:0])
    sy(2);
    rd(4'hc);
    `CHK("fill", 12'h927, d[11:0])
    sy(5);
    wr(4'h0, 32'h0039_0229);
    edges(4'h1);
    rd(4'hc);
    `CHK("pair", 12'h93f, d[11:0])
    wr(4'h0, 32'h0039_0081);
    @(posedge clk);
    sync_src[2] <= 1'b1;
    cnt(10, 2);
    @(posedge clk);
    sync_src[2] <= 1'b0;
    `CHK("dsync", 1, n)
    wr(4'h0, 32'h0039_0001);
    lat(8'h00, k);
    lat(8'h09, n);
    `CHK("dly", k + 9, n)
    wr(4'h0, 32'h0039_0000);
    rd(4'hc);
    l = d[31:16];
    rd(4'hc);
    `CHK("seed", 1'b1, l != 16'h0)
    repeat (2) l = l[0] ? ((l >> 1) ^ receive_input_pkg::LFSR_TAPS) : (l >> 1);
    `CHK("lfsr", l, d[31:16])
    conclude();
  end
endmodule
`default_nettype wire
